// file: awc_defs.vh
// Constants for the two-channel actuator waveform control block.
`ifndef AWC_DEFS_VH
`define AWC_DEFS_VH
// Parameter selector codes.
`define AWC_SEL_FIX_EN    4'h0
`define AWC_SEL_GAIN      4'h1
`define AWC_SEL_DELAY     4'h2
`define AWC_SEL_TYPE      4'h3
`define AWC_SEL_OUT_EN    4'h4
`define AWC_SEL_HALF_PER  4'h5
`define AWC_SEL_OFFSET    4'h6
`define AWC_SEL_NSEG      4'h7
`define AWC_SEL_SEGLEN    4'h8
`define AWC_SEL_INV_A     4'h9
`define AWC_SEL_INV_B     4'hA
`define AWC_SEL_FILT      4'hB
`define AWC_SEL_WDOG      4'hC
`define AWC_SEL_FIX_VAL   4'hD
`define AWC_SEL_MAX       8'h0D
`define AWC_SEL_ORIENT    8'h20
// Register port offsets.
`define AWC_OFF_SEL       4'h0
`define AWC_OFF_DATA      4'h1
`define AWC_OFF_STATUS    4'h2
`define AWC_OFF_ORIENT    4'h3
`define AWC_OFF_RDBACK    4'h4
// Field limits and resets.
`define AWC_GAIN_RST      8'h80
`define AWC_NSEG_MIN      8'h02
`define AWC_NSEG_RST      8'h02
`define AWC_SEGLEN_MIN    16'h0013
`define AWC_SEGLEN_MAX    16'h0FFF
`define AWC_SEGLEN_RST    16'h0013
`define AWC_DELAY_MAX     32'h0003_FFFF
`define AWC_ORIENT_MAX    8'h17
`define AWC_TYPE_NONE     8'h00
`define AWC_TYPE_3RD      8'h01
`define AWC_TYPE_EEPROM   8'h80
`define AWC_TYPE_MCU      8'h81
// Timing: clock in ps, delay step in ps, filter/watchdog unit in ns.
`define AWC_CLK_PS        4000
`define AWC_DLY_STEP_PS   133333
`define AWC_TICK_NS       60000
`define AWC_DLY_CYC       ((`AWC_DLY_STEP_PS) / (`AWC_CLK_PS))
`define AWC_TICK_CYC      ((`AWC_TICK_NS * 1000) / (`AWC_CLK_PS))
`endif

// file: awc_chan.v
// One waveform channel: edge filter, watchdog, delay, segments, scaling.
`timescale 1ns/1ps
`include "awc_defs.vh"
module awc_chan #(
  parameter TICK_CYC = `AWC_TICK_CYC
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // Settings
  input  wire        out_en,
  input  wire        fix_en,
  input  wire [7:0]  gain,
  input  wire [17:0] delay,
  input  wire [31:0] half_period_count,
  input  wire [7:0]  offset,
  input  wire [7:0]  nseg,
  input  wire [15:0] seglen,
  input  wire        inv_a,
  input  wire        inv_b,
  input  wire [7:0]  filt,
  input  wire [9:0]  wdog,
  input  wire [7:0]  fix_val,
  // Subframe edge, already synchronised
  input  wire        sf_edge,
  // Outputs
  output reg  [7:0]  dac_ff,
  output reg         pwm_a_ff,
  output reg         pwm_b_ff,
  output reg         oclk_ff,
  output reg         wd_fallback_ff
);
  localparam DLY_CYC = `AWC_DLY_CYC;
  reg [15:0] tick_cnt_ff;
  reg        tick;
  reg [9:0]  since_ff;
  reg        accept;
  reg [23:0] dly_cnt_ff;
  reg        dly_run_ff;
  reg [7:0]  seg_idx_ff;
  reg [15:0] seg_cnt_ff;
  reg        run_ff;
  reg [31:0] oclk_cnt_ff;
  reg [7:0]  pwm_cnt_ff;
  reg signed [7:0]  base;
  reg signed [17:0] scaled;
  reg signed [9:0]  summed;
  reg [7:0]  sample;
  always @*
  begin
    tick = (tick_cnt_ff == TICK_CYC[15:0] - 16'h0001);
    accept = sf_edge && ((filt == 8'h00) || (since_ff >= {2'b00, filt}));
    base = (seg_idx_ff[0]) ? 8'sh7F : -8'sh7F;
    if (fix_en || wd_fallback_ff || !run_ff)
      base = fix_val;
    scaled = base * $signed({10'h000, gain});
    summed = $signed(scaled[16:7]) + $signed({{2{offset[7]}}, offset});
    if (summed > 10'sh07F)
      sample = 8'h7F;
    else if (summed < -10'sh080)
      sample = 8'h80;
    else
      sample = summed[7:0];
  end
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      tick_cnt_ff <= 16'h0000;
      since_ff <= 10'h000;
      wd_fallback_ff <= 1'b0;
      dly_cnt_ff <= 24'h00_0000;
      dly_run_ff <= 1'b0;
      seg_idx_ff <= 8'h00;
      seg_cnt_ff <= 16'h0000;
      run_ff <= 1'b0;
      oclk_cnt_ff <= 32'h0000_0000;
      oclk_ff <= 1'b0;
      pwm_cnt_ff <= 8'h00;
      dac_ff <= 8'h00;
      pwm_a_ff <= 1'b0;
      pwm_b_ff <= 1'b0;
    end
    else
    begin
      tick_cnt_ff <= tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
      if (accept)
        since_ff <= 10'h000;
      else if (tick && since_ff != 10'h3FF)
        since_ff <= since_ff + 10'h001;
      if (accept)
        wd_fallback_ff <= 1'b0;
      else if (wdog != 10'h000 && since_ff >= wdog)
        wd_fallback_ff <= 1'b1;
      if (accept)
      begin
        dly_cnt_ff <= {6'h00, delay} * DLY_CYC[5:0];
        dly_run_ff <= 1'b1;
      end
      else if (dly_run_ff)
      begin
        if (dly_cnt_ff == 24'h00_0000)
        begin
          dly_run_ff <= 1'b0;
          run_ff <= 1'b1;
          seg_idx_ff <= 8'h00;
          seg_cnt_ff <= 16'h0000;
        end
        else
          dly_cnt_ff <= dly_cnt_ff - 24'h00_0001;
      end
      else if (run_ff)
      begin
        if (seg_cnt_ff >= seglen - 16'h0001)
        begin
          seg_cnt_ff <= 16'h0000;
          if (seg_idx_ff >= nseg - 8'h01)
            run_ff <= 1'b0;
          else
            seg_idx_ff <= seg_idx_ff + 8'h01;
        end
        else
          seg_cnt_ff <= seg_cnt_ff + 16'h0001;
      end
      // Disabling forces the clock low at once, not at the next phase end.
      if (oclk_cnt_ff >= half_period_count)
      begin
        oclk_cnt_ff <= 32'h0000_0000;
        oclk_ff <= ~oclk_ff & out_en;
      end
      else
      begin
        oclk_cnt_ff <= oclk_cnt_ff + 32'h0000_0001;
        oclk_ff <= oclk_ff & out_en;
      end
      pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
      dac_ff <= out_en ? sample : 8'h00;
      pwm_a_ff <= out_en & (((pwm_cnt_ff < (sample ^ 8'h80))) ^ inv_a);
      pwm_b_ff <= out_en & (((pwm_cnt_ff >= (sample ^ 8'h80))) ^ inv_b);
    end
  end
endmodule // awc_chan

// file: awc_top.v
// Two-channel actuator waveform control with parameter command port.
//
// Contract
// - Selector 0..13 with 32-bit data word
// - Channel byte selects channel 0 or 1
// - Fixed-output enable 0x01 on, 0x00 off
// - Unsigned u1.7 gain scales output
// - Subframe delay 0..262143 in 133.333ns steps; the code counts 33 clocks per step, 132ns at 4000 ps
// - Actuator type is a read-only byte
// - Output enable switches both channels together
// - Clock phases last half-period count plus one
// - Signed 8-bit offset added to output
// - Segment count accepted from 2 to 255
// - Segment length accepted from 19 to 4095
// - Invert PWM outputs on setting 0x01
// - Drop subframe edges closer than filter time
// - Watchdog forces fixed value until next edge
// - Fixed value drives output in fixed mode
// - Orientation 0..23 kept and read back
// - Orientation ignored at 1080p or lower
`timescale 1ns/1ps
`include "awc_defs.vh"
module awc_top #(
  parameter TICK_CYC = `AWC_TICK_CYC,
  parameter [7:0] ACT_TYPE = `AWC_TYPE_NONE
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // Register port
  input  wire [3:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata_ff,
  // Display status and subframe pins
  input  wire        res_le_1080p,
  input  wire        subframe_pin,
  // Orientation applied to the pixel shift
  output reg  [4:0]  pixel_shift_orient_ff,
  // Waveform outputs, channel 0 and 1
  output wire [15:0] dac,
  output wire [1:0]  pwm_a,
  output wire [1:0]  pwm_b,
  output wire [1:0]  out_clk,
  output wire [1:0]  wd_fallback
);
  reg [7:0]  sel_ff;
  reg [7:0]  chan_ff;
  reg        rej_ff;
  reg        out_en_ff;
  reg [1:0]  fix_en_ff;
  reg [7:0]  gain_ff [0:1];
  reg [17:0] delay_ff [0:1];
  reg [31:0] half_ff [0:1];
  reg [7:0]  offset_ff [0:1];
  reg [7:0]  nseg_ff [0:1];
  reg [15:0] seglen_ff [0:1];
  reg [1:0]  inv_a_ff;
  reg [1:0]  inv_b_ff;
  reg [7:0]  filt_ff [0:1];
  reg [9:0]  wdog_ff [0:1];
  reg [7:0]  fix_val_ff [0:1];
  reg [4:0]  orient_ff;
  reg [2:0]  sf_sync_ff;
  reg [31:0] rdback;
  reg        ok;
  wire       ch;
  wire       sf_edge;
  assign ch = chan_ff[0];
  // Two stages before the edge detector; the third stage is only the history bit.
  assign sf_edge = sf_sync_ff[1] & ~sf_sync_ff[2];
  always @*
  begin
    ok = (chan_ff <= 8'h01) && (sel_ff <= `AWC_SEL_MAX);
    case (sel_ff[3:0])
      `AWC_SEL_FIX_EN:   rdback = {31'h0, fix_en_ff[ch]};
      `AWC_SEL_GAIN:     rdback = {24'h0, gain_ff[ch]};
      `AWC_SEL_DELAY:    rdback = {14'h0, delay_ff[ch]};
      `AWC_SEL_TYPE:     rdback = {24'h0, ACT_TYPE};
      `AWC_SEL_OUT_EN:   rdback = {31'h0, out_en_ff};
      `AWC_SEL_HALF_PER: rdback = half_ff[ch];
      `AWC_SEL_OFFSET:   rdback = {24'h0, offset_ff[ch]};
      `AWC_SEL_NSEG:     rdback = {24'h0, nseg_ff[ch]};
      `AWC_SEL_SEGLEN:   rdback = {16'h0, seglen_ff[ch]};
      `AWC_SEL_INV_A:    rdback = {31'h0, inv_a_ff[ch]};
      `AWC_SEL_INV_B:    rdback = {31'h0, inv_b_ff[ch]};
      `AWC_SEL_FILT:     rdback = {24'h0, filt_ff[ch]};
      `AWC_SEL_WDOG:     rdback = {22'h0, wdog_ff[ch]};
      `AWC_SEL_FIX_VAL:  rdback = {24'h0, fix_val_ff[ch]};
      default:           rdback = 32'h0000_0000;
    endcase
    if (!ok)
      rdback = 32'h0000_0000;
  end
  integer i;
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sel_ff <= 8'h00;
      chan_ff <= 8'h00;
      rej_ff <= 1'b0;
      out_en_ff <= 1'b0;
      fix_en_ff <= 2'b00;
      inv_a_ff <= 2'b00;
      inv_b_ff <= 2'b00;
      orient_ff <= 5'h00;
      pixel_shift_orient_ff <= 5'h00;
      sf_sync_ff <= 3'b000;
      rdata_ff <= 32'h0000_0000;
      for (i = 0; i < 2; i = i + 1)
      begin
        gain_ff[i] <= `AWC_GAIN_RST;
        delay_ff[i] <= 18'h0_0000;
        half_ff[i] <= 32'h0000_0000;
        offset_ff[i] <= 8'h00;
        nseg_ff[i] <= `AWC_NSEG_RST;
        seglen_ff[i] <= `AWC_SEGLEN_RST;
        filt_ff[i] <= 8'h00;
        wdog_ff[i] <= 10'h000;
        fix_val_ff[i] <= 8'h00;
      end
    end
    else
    begin
      sf_sync_ff <= {sf_sync_ff[1:0], subframe_pin};
      if (!res_le_1080p)
        pixel_shift_orient_ff <= orient_ff;
      if (wr && addr == `AWC_OFF_SEL)
      begin
        sel_ff <= wdata[7:0];
        chan_ff <= wdata[15:8];
      end
      if (wr && addr == `AWC_OFF_ORIENT && wdata[7:0] <= `AWC_ORIENT_MAX)
        orient_ff <= wdata[4:0];
      if (wr && addr == `AWC_OFF_DATA)
      begin
        rej_ff <= !ok;
        if (ok)
        begin
          case (sel_ff[3:0])
            `AWC_SEL_FIX_EN:
              if (wdata[7:0] <= 8'h01)
                fix_en_ff[ch] <= wdata[0];
            `AWC_SEL_GAIN:     gain_ff[ch] <= wdata[7:0];
            `AWC_SEL_DELAY:
              if (wdata <= `AWC_DELAY_MAX)
                delay_ff[ch] <= wdata[17:0];
            `AWC_SEL_OUT_EN:
              if (wdata[7:0] <= 8'h01)
                out_en_ff <= wdata[0];
            `AWC_SEL_HALF_PER: half_ff[ch] <= wdata;
            `AWC_SEL_OFFSET:   offset_ff[ch] <= wdata[7:0];
            `AWC_SEL_NSEG:
              if (wdata[7:0] >= `AWC_NSEG_MIN)
                nseg_ff[ch] <= wdata[7:0];
            `AWC_SEL_SEGLEN:
              if (wdata[15:0] >= `AWC_SEGLEN_MIN && wdata[15:0] <= `AWC_SEGLEN_MAX)
                seglen_ff[ch] <= wdata[15:0];
            `AWC_SEL_INV_A:    inv_a_ff[ch] <= wdata[0];
            `AWC_SEL_INV_B:    inv_b_ff[ch] <= wdata[0];
            `AWC_SEL_FILT:     filt_ff[ch] <= wdata[7:0];
            `AWC_SEL_WDOG:     wdog_ff[ch] <= wdata[9:0];
            `AWC_SEL_FIX_VAL:  fix_val_ff[ch] <= wdata[7:0];
            default:           rej_ff <= 1'b0;
          endcase
        end
      end
      if (rd)
      begin
        case (addr)
          `AWC_OFF_SEL:    rdata_ff <= {16'h0000, chan_ff, sel_ff};
          `AWC_OFF_STATUS: rdata_ff <= {28'h0, wd_fallback, out_en_ff, rej_ff};
          `AWC_OFF_ORIENT: rdata_ff <= {27'h0, orient_ff};
          `AWC_OFF_RDBACK: rdata_ff <= rdback;
          default:         rdata_ff <= 32'h0000_0000;
        endcase
      end
      else
        rdata_ff <= 32'h0000_0000;
    end
  end
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_ch
      awc_chan #(
        .TICK_CYC (TICK_CYC)
      ) u_wave_gen (
        .ref_clk           (ref_clk),
        .reset             (reset),
        .out_en            (out_en_ff),
        .fix_en            (fix_en_ff[g]),
        .gain              (gain_ff[g]),
        .delay             (delay_ff[g]),
        .half_period_count (half_ff[g]),
        .offset            (offset_ff[g]),
        .nseg              (nseg_ff[g]),
        .seglen            (seglen_ff[g]),
        .inv_a             (inv_a_ff[g]),
        .inv_b             (inv_b_ff[g]),
        .filt              (filt_ff[g]),
        .wdog              (wdog_ff[g]),
        .fix_val           (fix_val_ff[g]),
        .sf_edge           (sf_edge),
        .dac_ff            (dac[g*8 +: 8]),
        .pwm_a_ff          (pwm_a[g]),
        .pwm_b_ff          (pwm_b[g]),
        .oclk_ff           (out_clk[g]),
        .wd_fallback_ff    (wd_fallback[g])
      );
    end
  endgenerate
endmodule // awc_top

// file: awc_checker.sv
// Port-level property checker for the actuator waveform control block.
`timescale 1ns/1ps
module awc_checker #(
  parameter [7:0] ACT_TYPE = 8'h00
) (
  // Clock and reset
  input wire        ref_clk,
  input wire        reset,
  // Register port
  input wire [3:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata_ff,
  // Display status and outputs
  input wire        res_le_1080p,
  input wire [4:0]  pixel_shift_orient_ff,
  input wire [15:0] dac,
  input wire [1:0]  pwm_a,
  input wire [1:0]  pwm_b,
  input wire [1:0]  out_clk
);
  reg  [7:0] sel_ff;
  reg  [7:0] chan_ff;
  reg  [4:0] ori_ff;
  reg        oe_ff;
  reg        rej_ff;
  wire       dwr = wr && addr == 4'h1;
  wire       bad = chan_ff > 8'h01 || sel_ff > 8'h0D;
  // Shadow of the request state so reads can be predicted.
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sel_ff  <= 8'h00;
      chan_ff <= 8'h00;
      ori_ff  <= 5'h00;
      oe_ff   <= 1'b0;
      rej_ff  <= 1'b0;
    end
    else
    begin
      if (wr && addr == 4'h0)
      begin
        sel_ff  <= wdata[7:0];
        chan_ff <= wdata[15:8];
      end
      if (wr && addr == 4'h3 && wdata <= 32'h0000_0017)
        ori_ff <= wdata[4:0];
      if (dwr)
        rej_ff <= bad;
      if (dwr && !bad && sel_ff == 8'h04 && wdata <= 32'h0000_0001)
        oe_ff <= wdata[0];
    end
  end
  chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(rd) |-> rdata_ff == 32'h0000_0000) else $error("read data not idle");
  chk_type_read: assert property (@(posedge ref_clk) disable iff (reset)
    rd && addr == 4'h4 && sel_ff == 8'h03 && chan_ff <= 8'h01
    |=> rdata_ff == {24'h00_0000, ACT_TYPE}) else $error("actuator type wrong");
  chk_orient_read: assert property (@(posedge ref_clk) disable iff (reset)
    rd && addr == 4'h3 |=> rdata_ff == {27'h000_0000, ori_ff}) else $error("orient read");
  chk_reject_flag: assert property (@(posedge ref_clk) disable iff (reset)
    rd && addr == 4'h2 |=> rdata_ff[0] == rej_ff) else $error("reject flag wrong");
  chk_status_oe: assert property (@(posedge ref_clk) disable iff (reset)
    rd && addr == 4'h2 |=> rdata_ff[1] == oe_ff) else $error("enable status wrong");
  chk_orient_range: assert property (@(posedge ref_clk) disable iff (reset)
    pixel_shift_orient_ff <= 5'h17) else $error("orientation out of range");
  chk_orient_frozen: assert property (@(posedge ref_clk) disable iff (reset)
    res_le_1080p |=> $stable(pixel_shift_orient_ff)) else $error("orientation moved");
  chk_off_quiet: assert property (@(posedge ref_clk) disable iff (reset)
    !oe_ff [*3] |-> dac == 16'h0000 && pwm_a == 2'h0 && pwm_b == 2'h0 && out_clk == 2'h0)
    else $error("outputs active while disabled");
endmodule // awc_checker
bind awc_top awc_checker #(.ACT_TYPE(ACT_TYPE)) u_chk (.ref_clk(ref_clk), .reset(reset),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
  .res_le_1080p(res_le_1080p), .pixel_shift_orient_ff(pixel_shift_orient_ff),
  .dac(dac), .pwm_a(pwm_a), .pwm_b(pwm_b), .out_clk(out_clk));

// file: awc_actuator_model.sv
// Behavioural actuator side: subframe source and output clock monitor.
`timescale 1ns/1ps
module awc_actuator_model (
  // Clock
  input  wire       ref_clk,
  // Waveform side
  input  wire       out_clk,
  // Subframe source and measurement
  output reg        subframe_pin,
  output reg  [7:0] hi_len
);
  reg [7:0] run;
  initial
  begin
    subframe_pin = 1'b0;
    hi_len = 8'h00;
    run = 8'h00;
  end
  // The high phase length is latched when the output clock falls.
  always @(posedge ref_clk)
  begin
    if (out_clk)
      run <= run + 8'h01;
    else
    begin
      if (run != 8'h00)
        hi_len <= run;
      run <= 8'h00;
    end
  end
  // Held for several cycles so the two-stage synchroniser cannot miss it.
  task subframe_pulse;
    begin
      subframe_pin <= 1'b1;
      repeat (4) @(posedge ref_clk);
      subframe_pin <= 1'b0;
    end
  endtask
endmodule // awc_actuator_model

// file: actuator_waveform_control_test.sv
// Self-checking bench for the actuator waveform control block.
`timescale 1ns/1ps
module actuator_waveform_control_test;
  reg         ref_clk;
  reg         reset;
  reg  [3:0]  addr;
  reg  [31:0] wdata;
  reg         wr;
  reg         rd;
  reg         res_le_1080p;
  wire [31:0] rdata_ff;
  wire [4:0]  orient;
  wire [15:0] dac;
  wire [1:0]  pwm_a;
  wire [1:0]  pwm_b;
  wire [1:0]  out_clk;
  wire [1:0]  wd_fb;
  wire        sf_pin;
  wire [7:0]  hi_len;
  integer     fails;
  integer     n_compared;
  integer     i;
  integer     na;
  integer     nb;
  reg  [31:0] r;
  // The top data byte stays zero in every request.
  function [31:0] val_of(input integer k);
    begin
      case (k)
        0, 4, 9, 10: val_of = 32'h0000_0001;
        1, 7, 11:    val_of = 32'h0000_00FF;
        2:           val_of = 32'h0003_FFFF;
        5:           val_of = 32'h0000_0007;
        6, 13:       val_of = 32'h0000_0080;
        8:           val_of = 32'h0000_0FFF;
        12:          val_of = 32'h0000_03FF;
        default:     val_of = 32'h0000_0000;
      endcase
    end
  endfunction
  awc_top #(.TICK_CYC(10), .ACT_TYPE(8'h81)) dut (.ref_clk(ref_clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
    .res_le_1080p(res_le_1080p), .subframe_pin(sf_pin), .pixel_shift_orient_ff(orient),
    .dac(dac), .pwm_a(pwm_a), .pwm_b(pwm_b), .out_clk(out_clk), .wd_fallback(wd_fb));
  awc_actuator_model act (.ref_clk(ref_clk), .out_clk(out_clk[0]),
    .subframe_pin(sf_pin), .hi_len(hi_len));
  task chk(input [31:0] seen, input [31:0] exp, input [127:0] what);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
        fails = fails + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wr_reg(input [3:0] a, input [31:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
    end
  endtask
  task rd_reg(input [3:0] a, output [31:0] v);
    begin
      addr <= a;
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(negedge ref_clk);
      v = rdata_ff;
      @(posedge ref_clk);
    end
  endtask
  task settle(input integer n);
    begin
      wr <= 1'b0;
      repeat (n) @(posedge ref_clk);
    end
  endtask
  task set_p(input [7:0] s, input [7:0] c, input [31:0] d);
    begin
      wr_reg(4'h0, {16'h0000, c, s});
      wr_reg(4'h1, d);
    end
  endtask
  task try(input [7:0] s, input [7:0] c, input [31:0] d, input [31:0] exp);
    begin
      set_p(s, c, d);
      wr_reg(4'h0, {16'h0000, c, s});
      rd_reg(4'h4, r);
      chk(r, exp, "param");
    end
  endtask
  task results;
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // The sequence needs about 500 cycles; this allows forty times that.
  initial
  begin
    #80000;
    fails = fails + 1;
    results;
  end
  initial
  begin
    fails = 0;
    n_compared = 0;
    reset = 1'b1;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    res_le_1080p = 1'b0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    try(8'h01, 8'h00, 32'h0000_0080, 32'h0000_0080);
    for (i = 0; i < 14; i = i + 1)
      if (i != 3)
        try(i[7:0], 8'h01, val_of(i), val_of(i));
    try(8'h03, 8'h01, 32'h0000_0000, 32'h0000_0081);
    try(8'h07, 8'h00, 32'h0000_0001, 32'h0000_0002);
    try(8'h07, 8'h01, 32'h0000_0002, 32'h0000_0002);
    try(8'h08, 8'h00, 32'h0000_1000, 32'h0000_0013);
    try(8'h08, 8'h01, 32'h0000_0012, 32'h0000_0FFF);
    try(8'h02, 8'h01, 32'h0004_0000, 32'h0003_FFFF);
    try(8'h04, 8'h00, 32'h0000_0001, 32'h0000_0001);
    try(8'h01, 8'h00, 32'h0000_0080, 32'h0000_0080);
    wr_reg(4'h0, 32'h0000_0101);
    rd_reg(4'h4, r);
    chk(r, 32'h0000_00FF, "chan1 gain");
    // Channel 2 aliases channel 0 in its low bit, so a leak would show there.
    set_p(8'h01, 8'h02, 32'h0000_0011);
    rd_reg(4'h2, r);
    chk({31'h0, r[0]}, 32'h0000_0001, "reject");
    wr_reg(4'h0, 32'h0000_0001);
    rd_reg(4'h4, r);
    chk(r, 32'h0000_0080, "kept gain");
    set_p(8'h0E, 8'h00, 32'h0000_0011);
    rd_reg(4'h2, r);
    chk({31'h0, r[0]}, 32'h0000_0001, "bad sel");
    try(8'h01, 8'h01, 32'h0000_00FF, 32'h0000_00FF);
    rd_reg(4'h2, r);
    chk({30'h0, r[1:0]}, 32'h0000_0002, "status");
    wr_reg(4'h3, 32'h0000_0017);
    wr_reg(4'h3, 32'h0000_0018);
    rd_reg(4'h3, r);
    chk(r, 32'h0000_0017, "orient");
    res_le_1080p <= 1'b1;
    wr_reg(4'h3, 32'h0000_0005);
    settle(3);
    chk({27'h0, orient}, 32'h0000_0017, "frozen");
    res_le_1080p <= 1'b0;
    settle(3);
    chk({27'h0, orient}, 32'h0000_0005, "applied");
    set_p(8'h05, 8'h00, 32'h0000_0003);
    settle(30);
    chk({24'h0, hi_len}, 32'h0000_0004, "clk high");
    set_p(8'h00, 8'h00, 32'h0000_0001);
    set_p(8'h0D, 8'h00, 32'h0000_0010);
    settle(4);
    chk({24'h0, dac[7:0]}, 32'h0000_0010, "fixed");
    set_p(8'h01, 8'h00, 32'h0000_0040);
    set_p(8'h06, 8'h00, 32'h0000_0005);
    settle(4);
    chk({24'h0, dac[7:0]}, 32'h0000_000D, "gain off");
    set_p(8'h04, 8'h01, 32'h0000_0000);
    settle(4);
    chk({16'h0, dac}, 32'h0000_0000, "disabled");
    set_p(8'h04, 8'h00, 32'h0000_0001);
    set_p(8'h00, 8'h00, 32'h0000_0000);
    set_p(8'h0C, 8'h00, 32'h0000_0002);
    settle(1);
    act.subframe_pulse;
    settle(8);
    chk({31'h0, wd_fb[0]}, 32'h0000_0000, "wd clear");
    chk({24'h0, dac[7:0]}, 32'h0000_00C5, "wave low");
    settle(40);
    chk({31'h0, wd_fb[0]}, 32'h0000_0001, "wd fire");
    chk({24'h0, dac[7:0]}, 32'h0000_000D, "wd value");
    chk({24'h0, dac[15:8]}, 32'h0000_0080, "ch1 fixed");
    // One full sweep of the PWM counter gives the duty as a count of high cycles.
    na = 0;
    nb = 0;
    repeat (256)
    begin
      @(negedge ref_clk);
      na = na + pwm_a[0];
      nb = nb + pwm_b[1];
    end
    chk(na, 32'h0000_008D, "pwm duty");
    chk(nb, 32'h0000_0000, "pwm invert");
    results;
  end
endmodule // actuator_waveform_control_test
